// *** include/sid_params.svh ***
// Purpose: Constants for the subtract instruction datapath
// Assumes: 14-bit instruction words, 8-bit data path
// Notes:   Register map offsets are word indices, decoded from Wishbone address bits 5:2
`ifndef SID_PARAMS_SVH
`define SID_PARAMS_SVH

// ================================================================
// Opcode fields
`define SID_OPC_LIT_HI     13
`define SID_OPC_LIT_LO     9
`define SID_OPC_LIT_VAL    5'h1e
`define SID_OPC_REG_HI     13
`define SID_OPC_REG_LO     8
`define SID_OPC_REG_VAL    6'h02
`define SID_DEST_BIT       7
`define SID_ADDR_HI        6
`define SID_NIB_BIT        4

// ================================================================
// Register map
`define SID_ADR_INSTR      4'h0
`define SID_ADR_ACC        4'h1
`define SID_ADR_STATUS     4'h2
`define SID_ADR_MEM_ADDR   4'h3
`define SID_ADR_MEM_DATA   4'h4
`define SID_ADR_LO         2
`define SID_ADR_HI         5
`define SID_ST_CARRY       0
`define SID_ST_NIB         1
`define SID_ST_ZERO        2
`define SID_ST_LAST_OK     3
`define SID_ACC_RST        8'h00
`define SID_STATUS_RST     4'h0

`endif

// *** include/sid_pkg.sv ***
// Purpose: Types for the subtract instruction datapath
// Assumes: sid_params.svh defines the constants
// Notes:   Flags travel as one packed struct
package sid_pkg;

    typedef struct packed {
        logic last_ok;
        logic zero;
        logic nibble_borrow_not;
        logic carry;
    } sid_flags_type;

    typedef enum logic [1:0] {
        SID_OP_NONE,
        SID_OP_LIT,
        SID_OP_REG
    } sid_op_type;

endpackage : sid_pkg

// *** src/sid_core.sv ***
// Purpose: Executes the literal and register subtract-accumulator-from-operand instructions
// Assumes: Software issues instructions by writing the instruction register over Wishbone
// Notes:   Each write to the instruction register executes in one cycle
`timescale 1ns/1ps
`default_nettype none
`include "sid_params.svh"

// Contract
// - The literal operation computes the low eight opcode bits minus the accumulator, selected by upper bits 11 110x.
// - The literal operation writes the accumulator, leaves data memory alone and updates borrow, nibble and zero flags.
// - The register operation, upper bits 00 0010, subtracts the accumulator from the register at the 7-bit address.
// - The register operation writes the accumulator when the destination bit is 0 and the register when it is 1.
// - The carry flag becomes 1 when the minuend is greater than or equal to the accumulator.
// - The carry flag becomes 0 when the accumulator exceeds the minuend, and the result wraps modulo 256.
module sid_core
    import sid_pkg::*;
#(
    parameter int DATA_W  = 8,
    parameter int MEM_DEP = 128
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);

    initial begin
        if (DATA_W != 8 || MEM_DEP != 128) begin
            $error("sid_core supports only an 8-bit path and 128 registers");
        end
    end

    // ================================================================
    // State
    logic [7:0]         acc_r, acc_nxt;
    sid_flags_type      flags_r, flags_nxt;
    logic [13:0]        instr_r, instr_nxt;
    logic [6:0]         mem_addr_r, mem_addr_nxt;
    logic [7:0]         mem_r [MEM_DEP];
    logic               mem_we;
    logic [6:0]         mem_wa;
    logic [7:0]         mem_wd;
    logic               ack_r, ack_nxt;
    logic [31:0]        rdat_r, rdat_nxt;

    // ================================================================
    // Bus decode
    logic       req;
    logic       wr_lo;
    logic [3:0] idx;

    assign req   = wb_cyc_i && wb_stb_i && !ack_r;
    // Writes land at the edge that samples ack high, while the request still stands
    assign wr_lo = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0];
    assign idx   = wb_adr_i[`SID_ADR_HI:`SID_ADR_LO];

    // ================================================================
    // Subtract datapath
    sid_op_type  op;
    logic [6:0]  f_addr;
    logic [7:0]  minuend;
    logic [8:0]  diff;
    logic [4:0]  nib_diff;
    logic [7:0]  result;
    logic        exec;

    assign exec   = wr_lo && idx == `SID_ADR_INSTR;
    assign f_addr = wb_dat_i[`SID_ADDR_HI:0];

    always_comb begin
        op = SID_OP_NONE;
        if (wb_dat_i[`SID_OPC_LIT_HI:`SID_OPC_LIT_LO] == `SID_OPC_LIT_VAL) begin
            op = SID_OP_LIT;
        end else if (wb_dat_i[`SID_OPC_REG_HI:`SID_OPC_REG_LO] == `SID_OPC_REG_VAL) begin
            op = SID_OP_REG;
        end
    end

    assign minuend  = (op == SID_OP_LIT) ? wb_dat_i[7:0] : mem_r[f_addr];
    assign diff     = {1'b0, minuend} - {1'b0, acc_r};
    assign nib_diff = {1'b0, minuend[3:0]} - {1'b0, acc_r[3:0]};
    assign result   = diff[7:0];

    // ================================================================
    // Next state
    always_comb begin
        acc_nxt      = acc_r;
        flags_nxt    = flags_r;
        instr_nxt    = instr_r;
        mem_addr_nxt = mem_addr_r;
        mem_we       = 1'b0;
        mem_wa       = f_addr;
        mem_wd       = result;
        ack_nxt      = req;
        rdat_nxt     = 32'h0000_0000;
        if (exec) begin
            instr_nxt = wb_dat_i[13:0];
            flags_nxt.last_ok = (op != SID_OP_NONE);
            if (op != SID_OP_NONE) begin
                flags_nxt.carry             = ~diff[8];
                flags_nxt.nibble_borrow_not = ~nib_diff[`SID_NIB_BIT];
                flags_nxt.zero              = (result == 8'h00);
                if (op == SID_OP_LIT || !wb_dat_i[`SID_DEST_BIT]) begin
                    acc_nxt = result;
                end else begin
                    mem_we = 1'b1;
                end
            end
        end else if (wr_lo) begin
            unique case (idx)
                `SID_ADR_ACC:      acc_nxt = wb_dat_i[7:0];
                `SID_ADR_MEM_ADDR: mem_addr_nxt = wb_dat_i[6:0];
                `SID_ADR_MEM_DATA: begin
                    mem_we = 1'b1;
                    mem_wa = mem_addr_r;
                    mem_wd = wb_dat_i[7:0];
                end
                default: ;
            endcase
        end
        if (req && !wb_we_i) begin
            unique case (idx)
                `SID_ADR_INSTR:    rdat_nxt = {18'h0, instr_r};
                `SID_ADR_ACC:      rdat_nxt = {24'h0, acc_r};
                `SID_ADR_STATUS:   rdat_nxt = {28'h0, flags_r};
                `SID_ADR_MEM_ADDR: rdat_nxt = {25'h0, mem_addr_r};
                `SID_ADR_MEM_DATA: rdat_nxt = {24'h0, mem_r[mem_addr_r]};
                default:           rdat_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ================================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_r      <= `SID_ACC_RST;
            flags_r    <= `SID_STATUS_RST;
            instr_r    <= 14'h0000;
            mem_addr_r <= 7'h00;
            ack_r      <= 1'b0;
            rdat_r     <= 32'h0000_0000;
        end else begin
            acc_r      <= acc_nxt;
            flags_r    <= flags_nxt;
            instr_r    <= instr_nxt;
            mem_addr_r <= mem_addr_nxt;
            ack_r      <= ack_nxt;
            rdat_r     <= rdat_nxt;
        end
    end

    // Data memory has no reset, as in a register file
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem_r[mem_wa] <= mem_wd;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // ================================================================
    // Checks
    a_lit_acc_result: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op == SID_OP_LIT |=> acc_r == $past(wb_dat_i[7:0]) - $past(acc_r))
        else $error("literal subtract result wrong");
    a_lit_no_mem: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op == SID_OP_LIT |-> !mem_we)
        else $error("literal subtract wrote memory");
    a_reg_minuend: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op == SID_OP_REG |-> minuend == mem_r[wb_dat_i[6:0]])
        else $error("register minuend not from addressed register");
    a_reg_dest_mem: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op == SID_OP_REG && wb_dat_i[7] |=> acc_r == $past(acc_r)
        && mem_r[$past(f_addr)] == $past(result))
        else $error("register subtract destination wrong");
    a_reg_dest_acc: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op == SID_OP_REG && !wb_dat_i[7] |=> acc_r == $past(result))
        else $error("accumulator destination not written");
    a_carry_set: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op != SID_OP_NONE && minuend >= acc_r |=> flags_r.carry)
        else $error("carry not set for non-negative result");
    a_carry_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op != SID_OP_NONE && minuend < acc_r |=> !flags_r.carry)
        else $error("carry not cleared for negative result");
    a_zero_nibble: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op != SID_OP_NONE |=> flags_r.zero == ($past(minuend) == $past(acc_r))
        && flags_r.nibble_borrow_not == ($past(minuend[3:0]) >= $past(acc_r[3:0])))
        else $error("zero or nibble flag wrong");
    a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");

    // ================================================================
    // Bus checks
    a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o)
        else $error("request not acknowledged");

    a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");

    a_idle_dat_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");

    a_read_acc: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && idx == `SID_ADR_ACC |=> wb_dat_o == {24'h0, $past(acc_r)})
        else $error("accumulator read wrong");

    a_read_status: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && idx == `SID_ADR_STATUS |=> wb_dat_o == {28'h0, $past(flags_r)})
        else $error("status read wrong");

    a_read_instr: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && idx == `SID_ADR_INSTR |=> wb_dat_o == {18'h0, $past(instr_r)})
        else $error("instruction read wrong");

    a_read_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && idx == `SID_ADR_MEM_ADDR |=> wb_dat_o == {25'h0, $past(mem_addr_r)})
        else $error("memory address read wrong");

    a_read_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && idx > `SID_ADR_MEM_DATA |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_write_acc: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_lo && idx == `SID_ADR_ACC |=> acc_r == $past(wb_dat_i[7:0]))
        else $error("accumulator write lost");

    a_write_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_lo && idx == `SID_ADR_MEM_ADDR |=> mem_addr_r == $past(wb_dat_i[6:0]))
        else $error("memory address write lost");

    a_write_mem: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_lo && idx == `SID_ADR_MEM_DATA |=> mem_r[$past(mem_addr_r)] == $past(wb_dat_i[7:0]))
        else $error("memory data write lost");

    a_no_write_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_lo |=> acc_r == $past(acc_r) && flags_r == $past(flags_r) && instr_r == $past(instr_r))
        else $error("state changed without a write");

    a_mem_we_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        mem_we |-> wr_lo)
        else $error("memory written without a bus write");

    // ================================================================
    // Instruction checks
    a_instr_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        exec |=> instr_r == $past(wb_dat_i[13:0]))
        else $error("instruction not latched");

    a_last_ok: assert property (@(posedge clk_i) disable iff (rst_i)
        exec |=> flags_r.last_ok == ($past(op) != SID_OP_NONE))
        else $error("recognised flag wrong");

    a_unknown_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op == SID_OP_NONE |=> acc_r == $past(acc_r) && flags_r[2:0] == $past(flags_r[2:0]))
        else $error("unknown opcode changed state");

    a_unknown_no_mem: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op == SID_OP_NONE |-> !mem_we)
        else $error("unknown opcode wrote memory");

    a_op_decode_lit: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_dat_i[`SID_OPC_LIT_HI:`SID_OPC_LIT_LO] == `SID_OPC_LIT_VAL |-> op == SID_OP_LIT)
        else $error("literal opcode not decoded");

    a_op_decode_reg: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_dat_i[`SID_OPC_REG_HI:`SID_OPC_REG_LO] == `SID_OPC_REG_VAL |-> op == SID_OP_REG)
        else $error("register opcode not decoded");

    a_lit_minuend: assert property (@(posedge clk_i) disable iff (rst_i)
        op == SID_OP_LIT |-> minuend == wb_dat_i[7:0])
        else $error("literal minuend wrong");

    // ================================================================
    // Result and flag checks
    a_lit_carry: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op == SID_OP_LIT |=> flags_r.carry == ($past(wb_dat_i[7:0]) >= $past(acc_r)))
        else $error("literal carry wrong");

    a_reg_acc_keep_mem: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op == SID_OP_REG && !wb_dat_i[`SID_DEST_BIT] |-> !mem_we)
        else $error("accumulator destination wrote memory");

    a_reg_dest_write: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op == SID_OP_REG && wb_dat_i[`SID_DEST_BIT] |-> mem_we && mem_wa == f_addr && mem_wd == result)
        else $error("register destination write wrong");

    a_result_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op != SID_OP_NONE && minuend < acc_r |-> result == 8'(minuend + ~acc_r + 8'h01))
        else $error("negative result does not wrap");

    a_zero_only: assert property (@(posedge clk_i) disable iff (rst_i)
        exec && op != SID_OP_NONE && result != 8'h00 |=> !flags_r.zero)
        else $error("zero flag set for nonzero result");


endmodule : sid_core
`default_nettype wire

// *** test/subtract_instruction_datapath_bench.sv ***
// Purpose: Self-checking bench for the subtract instruction datapath
// Assumes: Wishbone ack one cycle after the taking edge, byte lane 0 carries data
// Notes:   Random operands from a fixed seed, corner operands on the first passes
`timescale 1ns/1ps
`default_nettype none

module subtract_instruction_datapath_bench;
    import sid_pkg::*;

    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [5:0]  wb_adr_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [31:0] q;
    logic [31:0] seed;
    logic [7:0]  m, a, f;
    logic [13:0] opc;
    logic [11:0] e;
    logic        lit, d;
    int          failures;
    int          num_checks;

    sid_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

    // ================================================================
    // Clock, verdict and watchdog
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic give_verdict;
        if (failures == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        give_verdict();
    end

    // ================================================================
    // Bus cycle, comparison and expected values
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [5:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    // Status {recognised, zero, nibble borrow-not, borrow-not} and 8-bit result
    function automatic logic [11:0] exp_sub(input logic [7:0] mi, input logic [7:0] ac);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, mi} - {1'b0, ac};
        n = {1'b0, mi[3:0]} - {1'b0, ac[3:0]};
        return {1'b1, s[7:0] == 8'h00, ~n[4], ~s[8], s[7:0]};
    endfunction : exp_sub

    // ================================================================
    // Main sequence
    initial begin
        seed = 32'h5eed;
        failures = 0;
        num_checks = 0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 6'h04, '0); chk(q, 32'h0);
        wb(1'b0, 6'h08, '0); chk(q, 32'h0);
        for (int i = 0; i < 40; i++) begin
            {m, a, f} = 24'({$random(seed)} % 32'h1000000);
            {lit, d} = 2'(i % 4);
            if (i < 4) {m, a} = 16'h5a5a;
            else if (i < 8) {m, a} = 16'h00ff;
            else if (i < 12) {m, a} = 16'h10f1;
            else if (i < 16) {m, a} = 16'hff00;
            f[7] = 1'b0;
            opc = lit ? {5'h1e, f[0], m} : {6'h02, d, f[6:0]};
            e = exp_sub(m, a);
            wb(1'b1, 6'h0c, {24'h0, f});
            wb(1'b1, 6'h10, {24'h0, m});
            wb(1'b1, 6'h04, {24'h0, a});
            wb(1'b1, 6'h00, {18'h0, opc});
            wb(1'b0, 6'h00, '0); chk(q, {18'h0, opc});
            wb(1'b0, 6'h04, '0); chk(q, {24'h0, (lit || !d) ? e[7:0] : a});
            wb(1'b0, 6'h10, '0); chk(q, {24'h0, (!lit && d) ? e[7:0] : m});
            wb(1'b0, 6'h08, '0); chk(q, {28'h0, e[11:8]});
        end
        wb(1'b1, 6'h00, 32'h0);
        wb(1'b0, 6'h08, '0); chk(q, {28'h0, 1'b0, e[10:8]});
        wb(1'b0, 6'h14, '0); chk(q, 32'h0);
        give_verdict();
    end

endmodule : subtract_instruction_datapath_bench

`default_nettype wire
